/* File: src/stst_seq.sv */
// Initialization self-test sequencer with phase 3 status messages and APB registers.
//
// Behaviour
// - Self-test runs during link initialization phases 2 and 3, before normal mode.
// - Stage one averages raw offset over the first interval, stimulus off.
// - Stage two freezes offset cancellation for deflection interval plus 2 ms, stimulus on.
// - After half the deflection interval, average output over the remaining half.
// - Compare the self-test value with pass limits, then switch stimulus off.
// - Stage three averages offset over the third interval for normal data.
// - A passing result without a lock defect moves the device into normal operating mode.
// - A failing result reruns stages one to three, at most repeat-limit extra times.
// - Repetition stops as soon as one complete sequence passes.
// - Phase 3 sends busy, ready or defect messages by self-check progress.
// - Phase 3 lasts remaining self-test time in whole periods plus two periods.
// - Busy messages every period until done, then exactly two ready or defect.
// - Offset error gives defect messages only while the offset is out of limits.
// - Self-test failure gives defect messages latched until reset.
// - A cleared factory lock flag gives defect messages latched until reset.
// - Undervoltage stops all transmission until the supply recovers.
`timescale 1ns/1ps
module stst_seq
  import stst_pkg::*;
#(
  parameter int unsigned P_MS_CYC = MS_CYC,
  parameter int unsigned P_TX_CYC = TX_CYC
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Sensor path and link status
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample,
  input  wire logic               init_start,
  input  wire logic               init_phase3,
  input  wire logic               factory_lock_flag_a,
  input  wire logic               factory_lock_flag_b,
  input  wire logic               offset_error,
  input  wire logic               supply_low,
  // Sensor control and messages
  output logic                    stim_en,
  output logic                    oc_freeze,
  output logic signed [15:0]      normal_offset,
  output stst_msg_t               msg,
  output logic                    tx_enable,
  output logic                    normal_mode,
  output logic                    irq
);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == REG_CTRL) || (a == REG_WIN) || (a == REG_LIMIT) ||
              (a == REG_STATUS) || (a == REG_OFFSET) || (a == REG_ISTAT) ||
              (a == REG_IMASK);
  endfunction

  // Register state.
  logic [RPT_W-1:0]   rpt_lim_ff;
  logic [11:0]        win_ff;
  logic [31:0]        limit_ff;
  logic [IRQ_W-1:0]   istat_ff;
  logic [IRQ_W-1:0]   imask_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;
  logic               irq_ff;

  // Sequencer state.
  stst_state_t        state_ff;
  logic [RPT_W-1:0]   rep_ff;
  logic [15:0]        cnt_ff;
  logic [1:0]         ms_cnt_ff;
  logic               stim_ff;
  logic               freeze_ff;
  logic               st_ok_ff;
  logic               pass_ff;
  logic               fail_ff;
  logic               lock_ff;
  logic signed [15:0] st_value_ff;
  logic signed [15:0] offset_ff;

  // Phase 3 and messages.
  logic               ph3_ff;
  logic               post_ff;
  logic [1:0]         fin_cnt_ff;
  stst_msg_t          msg_ff;
  logic               tx_en_ff;
  logic               normal_ff;
  logic               uv_prev_ff;
  logic               ofs_prev_ff;

  logic               avg_start;
  logic [WIN_W-1:0]   avg_log2n;
  logic               avg_done;
  logic signed [15:0] avg_val;
  logic               ms_tick;
  logic               tx_tick;
  logic [WIN_W-1:0]   half2;
  logic               st_done;
  logic               defect_latched;
  logic               ev_pass;
  logic               ev_fail;
  logic               ev_lock;
  logic [IRQ_W-1:0]   nxt_events;
  stst_kind_t         nxt_kind;
  logic               wr_en;
  logic               send;

  assign wr_en          = psel && penable && pwrite && pready_ff;
  assign half2          = (win_ff[WIN2_LSB +: WIN_W] == 4'h0) ? 4'h0
                          : win_ff[WIN2_LSB +: WIN_W] - 4'h1;
  assign st_done        = (state_ff == S_DONE);
  assign defect_latched = fail_ff || lock_ff;

  // APB slave: zero wait states, answer registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_ok(paddr);
      prdata_ff  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          REG_CTRL:   prdata_ff <= 32'(rpt_lim_ff);
          REG_WIN:    prdata_ff <= 32'(win_ff);
          REG_LIMIT:  prdata_ff <= limit_ff;
          REG_STATUS: prdata_ff <= {st_value_ff, 5'h00, rep_ff, 2'h0, post_ff,
                                    normal_ff, lock_ff, fail_ff, pass_ff, st_done};
          REG_OFFSET: prdata_ff <= 32'(offset_ff);
          REG_ISTAT:  prdata_ff <= 32'(istat_ff);
          REG_IMASK:  prdata_ff <= 32'(imask_ff);
          default:    prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_lim_ff <= RPT_RST;
      win_ff     <= WIN_RST;
      limit_ff   <= LIMIT_RST;
      imask_ff   <= IMASK_RST;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) rpt_lim_ff <= pwdata[RPT_LSB +: RPT_W];
      if (paddr == REG_WIN) win_ff <= pwdata[11:0];
      if (paddr == REG_LIMIT) limit_ff <= pwdata;
      if (paddr == REG_IMASK) imask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // Interrupt status: a new event wins over a write-one clear.
  assign ev_lock = !lock_ff && !(factory_lock_flag_a && factory_lock_flag_b);
  always_comb begin
    nxt_events           = '0;
    nxt_events[IRQ_PASS] = ev_pass;
    nxt_events[IRQ_FAIL] = ev_fail;
    nxt_events[IRQ_LOCK] = ev_lock;
    nxt_events[IRQ_UV]   = supply_low && !uv_prev_ff;
    nxt_events[IRQ_OFS]  = offset_error && !ofs_prev_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff    <= '0;
      irq_ff      <= 1'b0;
      uv_prev_ff  <= 1'b0;
      ofs_prev_ff <= 1'b0;
    end else begin
      uv_prev_ff  <= supply_low;
      ofs_prev_ff <= offset_error;
      if (wr_en && paddr == REG_ISTAT) begin
        istat_ff <= (istat_ff & ~pwdata[IRQ_W-1:0]) | nxt_events;
      end else begin
        istat_ff <= istat_ff | nxt_events;
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  stst_tick #(.DIV(P_MS_CYC)) u_ms_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (state_ff != S_HOLD),
    .tick    (ms_tick)
  );

  stst_tick #(.DIV(P_TX_CYC)) u_tx_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (init_phase3 && !ph3_ff && !post_ff),
    .tick    (tx_tick)
  );

  stst_avg u_avg (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (avg_start),
    .log2n        (avg_log2n),
    .sample_valid (sample_valid),
    .sample       (sample),
    .done         (avg_done),
    .avg          (avg_val)
  );

  // Averager starts on entry to each averaging stage.
  always_comb begin
    avg_start = 1'b0;
    avg_log2n = win_ff[WIN1_LSB +: WIN_W];
    unique case (state_ff)
      S_IDLE: avg_start = init_start;
      S_ST1: avg_start = 1'b0;
      S_SETTLE: begin
        avg_start = sample_valid && (cnt_ff == (16'h0001 << half2) - 16'h0001);
        avg_log2n = half2;
      end
      S_ST2: avg_log2n = half2;
      S_HOLD: begin
        avg_start = ms_tick && (ms_cnt_ff == 2'(FREEZE_HOLD_MS - 1));
        avg_log2n = win_ff[WIN3_LSB +: WIN_W];
      end
      S_ST3: begin
        // A start from here opens a repeated stage one, so the first window applies.
        avg_log2n = win_ff[WIN1_LSB +: WIN_W];
        avg_start = avg_done && !st_ok_ff && (rep_ff < rpt_lim_ff);
      end
      S_DONE: avg_start = 1'b0;
    endcase
  end

  assign ev_pass = (state_ff == S_ST3) && avg_done && st_ok_ff;
  assign ev_fail = (state_ff == S_ST3) && avg_done && !st_ok_ff && (rep_ff >= rpt_lim_ff);

  // Self-test stage sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= S_IDLE;
      rep_ff      <= '0;
      cnt_ff      <= 16'h0000;
      ms_cnt_ff   <= 2'h0;
      stim_ff     <= 1'b0;
      freeze_ff   <= 1'b0;
      st_ok_ff    <= 1'b0;
      st_value_ff <= 16'sh0000;
      offset_ff   <= 16'sh0000;
    end else begin
      unique case (state_ff)
        S_IDLE: if (init_start) state_ff <= S_ST1;
        S_ST1: if (avg_done) begin
          offset_ff <= avg_val;
          state_ff  <= S_SETTLE;
          stim_ff   <= 1'b1;
          freeze_ff <= 1'b1;
          cnt_ff    <= 16'h0000;
        end
        S_SETTLE: if (avg_start) begin
          state_ff <= S_ST2;
        end else if (sample_valid) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
        S_ST2: if (avg_done) begin
          st_value_ff <= avg_val;
          st_ok_ff    <= (avg_val >= $signed(limit_ff[LIM_LO +: 16])) &&
                         (avg_val <= $signed(limit_ff[LIM_HI +: 16]));
          stim_ff     <= 1'b0;
          ms_cnt_ff   <= 2'h0;
          state_ff    <= S_HOLD;
        end
        S_HOLD: if (avg_start) begin
          freeze_ff <= 1'b0;
          state_ff  <= S_ST3;
        end else if (ms_tick) begin
          ms_cnt_ff <= ms_cnt_ff + 2'h1;
        end
        S_ST3: if (avg_done) begin
          offset_ff <= avg_val;
          if (st_ok_ff) begin
            state_ff <= S_DONE;
          end else if (rep_ff < rpt_lim_ff) begin
            rep_ff   <= rep_ff + 3'h1;
            state_ff <= S_ST1;
          end else begin
            state_ff <= S_DONE;
          end
        end
        S_DONE: state_ff <= S_DONE;
      endcase
    end
  end

  // Outcome and lock flags hold until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      if (ev_pass) pass_ff <= 1'b1;
      if (ev_fail) fail_ff <= 1'b1;
      if (ev_lock) lock_ff <= 1'b1;
    end
  end

  // Message kind for the next transmission slot.
  always_comb begin
    if (!post_ff) begin
      if (!st_done) nxt_kind = MSG_BUSY;
      else if (defect_latched) nxt_kind = MSG_DEFECT;
      else nxt_kind = MSG_READY;
    end else if (defect_latched || offset_error) begin
      nxt_kind = MSG_DEFECT;
    end else begin
      nxt_kind = MSG_DATA;
    end
  end

  // Undervoltage suppresses the slot entirely rather than delaying it.
  assign send = tx_tick && !supply_low && (ph3_ff || post_ff);

  // Phase 3 ends after the final ready or defect messages.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph3_ff     <= 1'b0;
      post_ff    <= 1'b0;
      fin_cnt_ff <= 2'h0;
      msg_ff     <= '0;
      tx_en_ff   <= 1'b0;
      normal_ff  <= 1'b0;
    end else begin
      tx_en_ff     <= !supply_low;
      msg_ff.valid <= send;
      if (send) msg_ff.kind <= nxt_kind;
      if (init_phase3 && !ph3_ff && !post_ff) ph3_ff <= 1'b1;
      if (send && ph3_ff && st_done) begin
        if (fin_cnt_ff == 2'(FINAL_MSGS - 1)) begin
          ph3_ff  <= 1'b0;
          post_ff <= 1'b1;
        end
        fin_cnt_ff <= fin_cnt_ff + 2'h1;
      end
      normal_ff <= post_ff && pass_ff && !lock_ff;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign irq           = irq_ff;
  assign stim_en       = stim_ff;
  assign oc_freeze     = freeze_ff;
  assign normal_offset = offset_ff;
  assign msg           = msg_ff;
  assign tx_enable     = tx_en_ff;
  assign normal_mode   = normal_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stim_in_stage2: assert property (stim_ff |-> (state_ff inside {S_SETTLE, S_ST2}))
    else $error("Stimulus on outside stage two.");
  a_freeze_covers_stim: assert property (stim_ff |-> freeze_ff)
    else $error("Stimulus on without frozen cancellation.");
  a_stim_off_check: assert property ((state_ff == S_ST2) && avg_done |=> !stim_ff && freeze_ff)
    else $error("Stimulus not released after check.");
  a_uv_silent: assert property (supply_low |=> !msg_ff.valid)
    else $error("Message sent under undervoltage.");
  a_fail_latched: assert property (fail_ff |=> fail_ff && !pass_ff)
    else $error("Failure flag lost before reset.");
  a_lock_defect: assert property (lock_ff && msg_ff.valid |-> msg_ff.kind != MSG_DATA)
    else $error("Data sent with lock defect.");
  a_busy_progress: assert property (send && !st_done |=> msg_ff.kind == MSG_BUSY)
    else $error("Non-busy message before self-test end.");
  a_repeat_bound: assert property (rep_ff <= rpt_lim_ff || $past(wr_en))
    else $error("Repeat count above limit.");
  a_normal_needs_pass: assert property (normal_ff |-> pass_ff && !fail_ff)
    else $error("Normal mode without passing self-test.");
  a_ofs_temporary: assert property (send && post_ff && !defect_latched |=>
                                    msg_ff.kind == ($past(offset_error) ? MSG_DEFECT : MSG_DATA))
    else $error("Offset error message kind wrong.");

  c_pass_first: cover property (ev_pass && rep_ff == 3'h0);
  c_pass_repeat: cover property (ev_pass && rep_ff != 3'h0);
  c_fail_final: cover property (ev_fail);
  c_normal_data: cover property (msg_ff.valid && msg_ff.kind == MSG_DATA);

endmodule

/* File: src/stst_pkg.sv */
// Shared constants, register map and carrier types of the self-test sequencer.
package stst_pkg;

  // Timing: clock period and documented intervals in their own units.
  localparam int unsigned CLK_PERIOD_PS  = 4_000;
  localparam int unsigned MS_PS          = 1_000_000_000;
  localparam int unsigned TX_PERIOD_PS   = 228_000_000;
  localparam int unsigned FREEZE_HOLD_MS = 2;
  localparam int unsigned FINAL_MSGS     = 2;

  // A least time rounds up to whole cycles.
  localparam int unsigned MS_CYC = (MS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TX_CYC = (TX_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WIN    = 8'h04;
  localparam logic [7:0] REG_LIMIT  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_OFFSET = 8'h10;
  localparam logic [7:0] REG_ISTAT  = 8'h14;
  localparam logic [7:0] REG_IMASK  = 8'h18;

  // Field positions.
  localparam int unsigned RPT_LSB   = 0;
  localparam int unsigned RPT_W     = 3;
  localparam int unsigned WIN1_LSB  = 0;
  localparam int unsigned WIN2_LSB  = 4;
  localparam int unsigned WIN3_LSB  = 8;
  localparam int unsigned WIN_W     = 4;
  localparam int unsigned LIM_LO    = 0;
  localparam int unsigned LIM_HI    = 16;
  localparam int unsigned IRQ_PASS  = 0;
  localparam int unsigned IRQ_FAIL  = 1;
  localparam int unsigned IRQ_LOCK  = 2;
  localparam int unsigned IRQ_UV    = 3;
  localparam int unsigned IRQ_OFS   = 4;
  localparam int unsigned IRQ_W     = 5;

  // Reset values.
  localparam logic [RPT_W-1:0]   RPT_RST   = 3'h0;
  localparam logic [11:0]        WIN_RST   = 12'h8a8;
  localparam logic [31:0]        LIMIT_RST = 32'h7fff_0100;
  localparam logic [IRQ_W-1:0]   IMASK_RST = 5'h00;

  typedef enum logic [1:0] {
    MSG_DATA,
    MSG_BUSY,
    MSG_READY,
    MSG_DEFECT
  } stst_kind_t;

  typedef struct packed {
    logic       valid;
    stst_kind_t kind;
  } stst_msg_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ST1,
    S_SETTLE,
    S_ST2,
    S_HOLD,
    S_ST3,
    S_DONE
  } stst_state_t;

endpackage

/* File: src/stst_tick.sv */
// Clearable divider that emits a one-cycle enable pulse every DIV cycles.
`timescale 1ns/1ps
module stst_tick
  import stst_pkg::*;
#(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic clr,
  output logic      tick
);

  logic [31:0] cnt_ff;
  logic        tick_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (clr) begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff == 32'(DIV - 1)) begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule

/* File: src/stst_avg.sv */
// Averager over a power-of-two number of samples.
`timescale 1ns/1ps
module stst_avg
  import stst_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Control
  input  wire logic               start,
  input  wire logic [WIN_W-1:0]   log2n,
  // Samples
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample,
  // Result
  output logic                    done,
  output logic signed [15:0]      avg
);

  logic signed [31:0] acc_ff;
  logic [15:0]        cnt_ff;
  logic [WIN_W-1:0]   n_ff;
  logic               busy_ff;
  logic               done_ff;
  logic signed [15:0] avg_ff;
  logic signed [31:0] nxt_acc;

  assign nxt_acc = acc_ff + 32'(sample);

  // A power-of-two window keeps the divide to a shift.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff  <= 32'sh0000_0000;
      cnt_ff  <= 16'h0000;
      n_ff    <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      avg_ff  <= 16'sh0000;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        acc_ff  <= 32'sh0000_0000;
        cnt_ff  <= 16'h0000;
        n_ff    <= log2n;
        busy_ff <= 1'b1;
      end else if (busy_ff && sample_valid) begin
        acc_ff <= nxt_acc;
        cnt_ff <= cnt_ff + 16'h0001;
        if (cnt_ff == (16'h0001 << n_ff) - 16'h0001) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          avg_ff  <= 16'(nxt_acc >>> n_ff);
        end
      end
    end
  end

  assign done = done_ff;
  assign avg  = avg_ff;

endmodule

/* File: tb/stst_rx_model.sv */
// Receiver model that tallies the sensor's phase 3 status messages.
`timescale 1ns/1ps
module stst_rx_model
  import stst_pkg::*;
(
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Link from the sensor
  input  wire stst_msg_t msg,
  // Tallies
  output int             n_msg,
  output int             n_ready,
  output int             n_bad,
  output stst_kind_t     last_kind
);
  logic got_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_msg <= 0;
      n_ready <= 0;
      n_bad <= 0;
      got_ready <= 1'b0;
      last_kind <= MSG_DATA;
    end else if (msg.valid) begin
      n_msg <= n_msg + 1;
      last_kind <= msg.kind;
      if (msg.kind == MSG_READY) begin
        n_ready <= n_ready + 1;
        got_ready <= 1'b1;
      end
      // Data before a ready message would be thrown away by a real receiver.
      if (msg.kind == MSG_DATA && !got_ready) begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule

/* File: tb/init_self_test_sequencer_tb_top.sv */
// Self-checking bench for the initialization self-test sequencer.
`timescale 1ns/1ps
module init_self_test_sequencer_tb_top;
  import stst_pkg::*;
  localparam int TXC = 50;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               sample_valid, init_start, init_phase3, factory_lock_flag_a;
  logic               offset_error, supply_low, stim_en, oc_freeze, tx_enable;
  logic               normal_mode, irq, seen_hold, factory_lock_flag_b;
  logic signed [15:0] sample, normal_offset;
  stst_msg_t          msg;
  stst_kind_t         last_kind;
  int                 n_msg, n_ready, n_bad, err_count, checks, m;

  stst_seq #(.P_MS_CYC(20), .P_TX_CYC(TXC)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid, .sample,
    .init_start, .init_phase3, .factory_lock_flag_a, .factory_lock_flag_b,
    .offset_error, .supply_low, .stim_en, .oc_freeze, .normal_offset, .msg,
    .tx_enable, .normal_mode, .irq);
  stst_rx_model rx (.pclk, .presetn, .msg, .n_msg, .n_ready, .n_bad, .last_kind);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The stimulus shifts the reading, so a frozen deflection shows in the result.
  always @(posedge pclk) begin
    sample_valid <= presetn & ~sample_valid;
    sample <= stim_en ? 16'sh0100 : 16'sh0010;
    seen_hold <= presetn & (seen_hold | (oc_freeze & ~stim_en));
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic to_fail;
    err_count++;
    report_and_stop();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) to_fail();
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from driving psel twice in one step.
    @(posedge pclk);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // Starts self-test, opens phase 3 and polls until the final messages are out.
  task automatic run_init(input logic [31:0] ctrl, input logic [31:0] lim);
    int n;
    n = 0;
    apb(1'b1, REG_CTRL, ctrl);
    apb(1'b1, REG_WIN, 32'h0000_0222);
    apb(1'b1, REG_LIMIT, lim);
    apb(1'b1, REG_IMASK, 32'h0000_0003);
    init_start <= 1'b1;
    @(posedge pclk);
    init_start <= 1'b0;
    repeat (4) @(posedge pclk);
    init_phase3 <= 1'b1;
    @(posedge pclk);
    init_phase3 <= 1'b0;
    do begin
      repeat (20) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
      if (n > 500) to_fail();
    end while (rd[5] !== 1'b1);
    // Normal mode trails the post-phase flag by a cycle, so read the status once more.
    apb(1'b0, REG_STATUS, 32'h0000_0000);
  endtask

  task automatic t_regs;
    do_reset();
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, REG_WIN, 32'h0000_0000);
    chk(rd, 32'h0000_08a8);
    apb(1'b0, REG_LIMIT, 32'h0000_0000);
    chk(rd, 32'h7fff_0100);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk({rd[30:0], e}, 32'h0000_0001);
  endtask

  task automatic t_pass;
    do_reset();
    run_init(32'h0000_0003, 32'h0200_0080);
    chk(rd & 32'h0000_073f, 32'h0000_0033);
    chk({31'h0, normal_mode}, 32'h0000_0001);
    chk(32'(n_ready), 32'h0000_0002);
    chk({31'h0, seen_hold}, 32'h0000_0001);
    chk(32'(normal_offset), 32'h0000_0010);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, REG_ISTAT, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    offset_error <= 1'b1;
    repeat (2 * TXC + 5) @(posedge pclk);
    chk(32'(last_kind), 32'(MSG_DEFECT));
    offset_error <= 1'b0;
    repeat (2 * TXC + 5) @(posedge pclk);
    chk(32'(last_kind), 32'(MSG_DATA));
    supply_low <= 1'b1;
    repeat (3) @(posedge pclk);
    m = n_msg;
    repeat (3 * TXC) @(posedge pclk);
    chk(32'(n_msg - m), 32'h0000_0000);
    chk({31'h0, tx_enable}, 32'h0000_0000);
    supply_low <= 1'b0;
    repeat (2 * TXC + 5) @(posedge pclk);
    chk({31'h0, n_msg > m}, 32'h0000_0001);
    chk(32'(n_bad), 32'h0000_0000);
  endtask

  task automatic t_fail(input int l);
    do_reset();
    run_init(32'(l), 32'h0400_0300);
    chk(rd & 32'h0000_073f, 32'h0000_0025 | 32'(l << 8));
    chk({31'h0, normal_mode}, 32'h0000_0000);
    chk(32'(n_ready), 32'h0000_0000);
    repeat (2 * TXC + 5) @(posedge pclk);
    chk(32'(last_kind), 32'(MSG_DEFECT));
    chk({31'h0, irq}, 32'h0000_0001);
  endtask

  task automatic t_lock(input logic a_low);
    {factory_lock_flag_a, factory_lock_flag_b} <= a_low ? 2'b01 : 2'b10;
    do_reset();
    {factory_lock_flag_a, factory_lock_flag_b} <= 2'b11;
    run_init(32'h0000_0000, 32'h0200_0080);
    chk(rd & 32'h0000_003f, 32'h0000_002b);
    chk({31'h0, normal_mode}, 32'h0000_0000);
    chk(32'(last_kind), 32'(MSG_DEFECT));
  endtask

  initial begin
    {presetn, psel, penable, pwrite, init_start, init_phase3} = 6'h00;
    {offset_error, supply_low} = 2'h0;
    factory_lock_flag_a = 1'b1;
    factory_lock_flag_b = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_count = 0;
    checks = 0;
    t_regs();
    t_pass();
    for (int l = 0; l < 6; l++) begin
      t_fail(l);
    end
    t_lock(1'b1);
    t_lock(1'b0);
    report_and_stop();
  end
endmodule
